// [rtl/aic_top.sv]
// Purpose: Analog command input conditioning with register port
// Assumes: Samples arrive as signed millivolts with a valid strobe
// Notes:   Percent values are in 0.1 percent units

`timescale 1ns/10ps
`default_nettype none

module aic_top #(
    parameter int CYCLES_PER_MS = aic_pkg::MS_CYCLES
) (
    input  wire logic                     clk_i,
    input  wire logic                     reset_n_i,
    input  wire aic_pkg::aic_reg_req_type reg_req_i,
    output var  logic [15:0]              reg_rdata_o,
    input  wire aic_pkg::aic_sample_type  sample_i,
    input  wire logic                     din_cal_i,
    output var  logic [31:0]              speed_cmd_o,
    output var  logic [15:0]              torque_pct_o
);
    import aic_pkg::*;

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    if (CYCLES_PER_MS < 1 || CYCLES_PER_MS > 65535) begin : g_chk
        $error("CYCLES_PER_MS out of range");
    end

    // ****************************************************************
    // Millisecond tick
    // ****************************************************************
    localparam logic [15:0] TICK_LAST = 16'(CYCLES_PER_MS - 1);

    logic [15:0] tick_cnt;
    logic        tick;
    wire         tick_wrap = (tick_cnt == TICK_LAST);

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            tick_cnt <= '0;
            tick     <= 1'b0;
        end else begin
            tick_cnt <= tick_wrap ? 16'h0000 : tick_cnt + 16'h0001;
            tick     <= tick_wrap;
        end
    end

    // ****************************************************************
    // Register port decode
    // ****************************************************************
    wire                 wr      = reg_req_i.wr;
    wire  [ADDR_W-1:0]   addr    = reg_req_i.addr;
    wire  [DATA_W-1:0]   wdata   = reg_req_i.wdata;
    wire                 wr_cal  = wr && (addr == REG_CAL_TRIGGER);
    wire                 wr_rate = wr && (addr == REG_RATED_SPEED);
    wire                 wr_src  = wr && (addr == REG_CMD_SOURCE);
    wire  [CAL_W-1:0]    code    = wdata[CAL_W-1:0];

    // ****************************************************************
    // Calibration triggers
    // ****************************************************************
    logic din_prev;
    wire  din_fall = din_prev && !din_cal_i;

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            din_prev <= 1'b0;
        end else begin
            din_prev <= din_cal_i;
        end
    end

    logic [NUM_CH-1:0] cal_req;
    assign cal_req[0] = (wr_cal && (code == CAL_CH1 || code == CAL_ALL))
                        || din_fall;
    assign cal_req[1] = (wr_cal && (code == CAL_CH2 || code == CAL_ALL))
                        || din_fall;

    // ****************************************************************
    // Per-channel settings and datapath
    // ****************************************************************
    aic_chan_cfg_type  cfg  [NUM_CH];
    logic [DATA_W-1:0] volt [NUM_CH];
    logic [DATA_W-1:0] filt [NUM_CH];
    logic [DATA_W-1:0] pct  [NUM_CH];

    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        wire hit_bias = wr && (addr == reg_index(c, FLD_BIAS));
        wire hit_dz   = wr && (addr == reg_index(c, FLD_DEAD_ZONE));
        wire hit_mag  = wr && (addr == reg_index(c, FLD_MAG));
        wire hit_tc   = wr && (addr == reg_index(c, FLD_FILTER_TC));
        wire hit_zd   = wr && (addr == reg_index(c, FLD_ZERO_DRIFT));

        always_ff @(posedge clk_i) begin
            if (!reset_n_i) begin
                cfg[c].bias          <= BIAS_RESET;
                cfg[c].dead_zone     <= DZ_RESET;
                cfg[c].magnification <= MAG_RESET;
                cfg[c].filter_tc     <= TC_RESET;
                cfg[c].zero_drift    <= ZD_RESET;
                volt[c]              <= '0;
            end else begin
                if (sample_i.valid) begin
                    volt[c] <= sample_i.mv[c];
                end
                if (hit_bias) begin
                    cfg[c].bias <= wdata;
                end
                if (hit_dz) begin
                    cfg[c].dead_zone <= wdata;
                end
                if (hit_mag) begin
                    cfg[c].magnification <= wdata;
                end
                if (hit_tc) begin
                    cfg[c].filter_tc <= wdata;
                end
                // Correction wins over a software write
                if (cal_req[c]) begin
                    cfg[c].zero_drift <= filt[c];
                end else if (hit_zd) begin
                    cfg[c].zero_drift <= wdata;
                end
            end
        end

        aic_lpf u_lpf (
            .clk_i          (clk_i),
            .reset_n_i      (reset_n_i),
            .sample_valid_i (sample_i.valid),
            .x_i            (sample_i.mv[c]),
            .tick_i         (tick),
            .tc_i           (cfg[c].filter_tc),
            .y_o            (filt[c])
        );

        aic_cmd_calc u_calc (
            .clk_i     (clk_i),
            .reset_n_i (reset_n_i),
            .filt_i    (filt[c]),
            .cfg_i     (cfg[c]),
            .pct_o     (pct[c])
        );
    end

    // ****************************************************************
    // Global settings
    // ****************************************************************
    logic [CAL_W-1:0]  cal_code;
    logic [DATA_W-1:0] rated_speed;
    logic              cmd_src;

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            cal_code    <= CAL_NONE;
            rated_speed <= RATED_RESET;
            cmd_src     <= 1'b0;
        end else begin
            if (wr_cal) begin
                cal_code <= code;
            end
            if (wr_rate) begin
                rated_speed <= wdata;
            end
            if (wr_src) begin
                cmd_src <= wdata[0];
            end
        end
    end

    // ****************************************************************
    // Speed and torque commands
    // ****************************************************************
    wire        [15:0] pct_sel = cmd_src ? pct[1] : pct[0];
    wire signed [33:0] spd_prod = $signed(pct_sel)
                                  * $signed({1'b0, rated_speed});
    wire signed [33:0] spd_quo  = spd_prod / 34'(PCT_UNIT_DIV);

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            speed_cmd_o  <= '0;
            torque_pct_o <= '0;
        end else begin
            speed_cmd_o  <= spd_quo[31:0];
            torque_pct_o <= pct_sel;
        end
    end

    // ****************************************************************
    // Read data
    // ****************************************************************
    logic [DATA_W-1:0] rd_value;

    always_comb begin
        rd_value = '0;
        case (addr)
            REG_CH1_VOLT:                      rd_value = volt[0];
            REG_CH2_VOLT:                      rd_value = volt[1];
            reg_index(0, FLD_BIAS):            rd_value = cfg[0].bias;
            reg_index(0, FLD_DEAD_ZONE):       rd_value = cfg[0].dead_zone;
            reg_index(0, FLD_MAG):             rd_value = cfg[0].magnification;
            reg_index(0, FLD_FILTER_TC):       rd_value = cfg[0].filter_tc;
            reg_index(0, FLD_ZERO_DRIFT):      rd_value = cfg[0].zero_drift;
            reg_index(1, FLD_BIAS):            rd_value = cfg[1].bias;
            reg_index(1, FLD_DEAD_ZONE):       rd_value = cfg[1].dead_zone;
            reg_index(1, FLD_MAG):             rd_value = cfg[1].magnification;
            reg_index(1, FLD_FILTER_TC):       rd_value = cfg[1].filter_tc;
            reg_index(1, FLD_ZERO_DRIFT):      rd_value = cfg[1].zero_drift;
            REG_CAL_TRIGGER:                   rd_value = 16'(cal_code);
            REG_RATED_SPEED:                   rd_value = rated_speed;
            REG_CH1_PCT:                       rd_value = pct[0];
            REG_CH2_PCT:                       rd_value = pct[1];
            REG_CMD_SOURCE:                    rd_value = 16'(cmd_src);
            default:                           rd_value = '0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            reg_rdata_o <= '0;
        end else begin
            reg_rdata_o <= reg_req_i.rd ? rd_value : 16'h0000;
        end
    end

endmodule : aic_top

`default_nettype wire

// [rtl/aic_pkg.sv]
// Purpose: Shared constants and types for the analog input conditioning block
// Assumes: 40 MHz clock, samples already converted to signed millivolts
// Notes:   Register indices are word indices on the plain register port

package aic_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 25;
    localparam int MS_TIME_NS    = 1000000;
    localparam int MS_CYCLES     = MS_TIME_NS / CLK_PERIOD_NS;

    // ****************************************************************
    // Sizes and scaling
    // ****************************************************************
    localparam int NUM_CH        = 2;
    localparam int DATA_W        = 16;
    localparam int ADDR_W        = 5;
    localparam int CAL_W         = 3;
    localparam int FULL_SCALE_MV = 10000;
    localparam int PCT_UNIT_DIV  = 1000;
    localparam int PCT_MAX       = 32767;
    localparam int FRAC_W        = 16;
    localparam int SHIFT_MAX     = 15;

    // ****************************************************************
    // Register indices
    // ****************************************************************
    localparam logic [ADDR_W-1:0] REG_CH1_VOLT    = 5'h00;
    localparam logic [ADDR_W-1:0] REG_CH2_VOLT    = 5'h01;
    localparam logic [ADDR_W-1:0] REG_CH1_BASE    = 5'h02;
    localparam logic [ADDR_W-1:0] REG_CH_STRIDE   = 5'h05;
    localparam logic [ADDR_W-1:0] FLD_BIAS        = 5'h00;
    localparam logic [ADDR_W-1:0] FLD_DEAD_ZONE   = 5'h01;
    localparam logic [ADDR_W-1:0] FLD_MAG         = 5'h02;
    localparam logic [ADDR_W-1:0] FLD_FILTER_TC   = 5'h03;
    localparam logic [ADDR_W-1:0] FLD_ZERO_DRIFT  = 5'h04;
    localparam logic [ADDR_W-1:0] REG_CAL_TRIGGER = 5'h0c;
    localparam logic [ADDR_W-1:0] REG_RATED_SPEED = 5'h0d;
    localparam logic [ADDR_W-1:0] REG_CH1_PCT     = 5'h0e;
    localparam logic [ADDR_W-1:0] REG_CH2_PCT     = 5'h0f;
    localparam logic [ADDR_W-1:0] REG_CMD_SOURCE  = 5'h10;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [DATA_W-1:0] BIAS_RESET   = 16'h0000;
    localparam logic [DATA_W-1:0] DZ_RESET     = 16'h0000;
    localparam logic [DATA_W-1:0] MAG_RESET    = 16'h03e8;
    localparam logic [DATA_W-1:0] TC_RESET     = 16'h0002;
    localparam logic [DATA_W-1:0] ZD_RESET     = 16'h0000;
    localparam logic [DATA_W-1:0] RATED_RESET  = 16'h0bb8;

    // ****************************************************************
    // Calibration trigger codes
    // ****************************************************************
    localparam logic [CAL_W-1:0] CAL_NONE = 3'h0;
    localparam logic [CAL_W-1:0] CAL_CH1  = 3'h1;
    localparam logic [CAL_W-1:0] CAL_CH2  = 3'h2;
    localparam logic [CAL_W-1:0] CAL_CH3  = 3'h3;
    localparam logic [CAL_W-1:0] CAL_ALL  = 3'h4;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef struct packed {
        logic [DATA_W-1:0] bias;
        logic [DATA_W-1:0] dead_zone;
        logic [DATA_W-1:0] magnification;
        logic [DATA_W-1:0] filter_tc;
        logic [DATA_W-1:0] zero_drift;
    } aic_chan_cfg_type;

    typedef struct packed {
        logic                          valid;
        logic [NUM_CH-1:0][DATA_W-1:0] mv;
    } aic_sample_type;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } aic_reg_req_type;

    function automatic logic [ADDR_W-1:0] reg_index(input int ch,
                                                    input logic [ADDR_W-1:0] fld);
        reg_index = ADDR_W'(REG_CH1_BASE + ADDR_W'(ch) * REG_CH_STRIDE + fld);
    endfunction : reg_index

endpackage : aic_pkg

// [rtl/aic_lpf.sv]
// Purpose: First-order low-pass filter on one channel of millivolt samples
// Assumes: tick_i pulses once per millisecond
// Notes:   Time constant becomes the smallest power of two of milliseconds above it, capped at 2**15; zero bypasses

`timescale 1ns/10ps
`default_nettype none

module aic_lpf (
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        sample_valid_i,
    input  wire logic [15:0] x_i,
    input  wire logic        tick_i,
    input  wire logic [15:0] tc_i,
    output var  logic [15:0] y_o
);
    import aic_pkg::*;

    // Shift k with 2**k >= tc + 1, capped
    function automatic logic [3:0] shift_of(input logic [15:0] tc);
        logic [3:0] k;
        k = 4'h0;
        for (int i = 0; i < SHIFT_MAX; i++) begin
            if ((32'(tc) + 32'd1) > (32'd1 << i)) begin
                k = 4'(i + 1);
            end
        end
        shift_of = k;
    endfunction : shift_of

    logic signed [31:0] acc;
    logic        [15:0] x_hold;
    wire  signed [32:0] target   = $signed({x_hold[15], x_hold, 16'h0000});
    wire  signed [32:0] diff     = target - {acc[31], acc};
    wire  signed [32:0] step     = diff >>> shift_of(tc_i);
    wire  signed [31:0] next_acc = acc + 32'(step);
    wire                bypass   = (tc_i == 16'h0000);

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            acc    <= '0;
            x_hold <= '0;
            y_o    <= '0;
        end else begin
            if (sample_valid_i) begin
                x_hold <= x_i;
            end
            if (bypass) begin
                if (sample_valid_i) begin
                    acc <= $signed({x_i, 16'h0000});
                    y_o <= x_i;
                end
            end else if (tick_i) begin
                acc <= next_acc;
                y_o <= next_acc[31:FRAC_W];
            end
        end
    end

endmodule : aic_lpf

`default_nettype wire

// [rtl/aic_cmd_calc.sv]
// Purpose: Zero drift, bias, dead zone and magnification for one channel
// Assumes: Settings are sampled every cycle
// Notes:   Result is in units of 0.1 percent, saturated to 16 bits

`timescale 1ns/10ps
`default_nettype none

module aic_cmd_calc (
    input  wire logic                      clk_i,
    input  wire logic                      reset_n_i,
    input  wire logic [15:0]               filt_i,
    input  wire aic_pkg::aic_chan_cfg_type cfg_i,
    output var  logic [15:0]               pct_o
);
    import aic_pkg::*;

    wire signed [17:0] filt_x = 18'($signed(filt_i));
    wire signed [17:0] zd_x   = 18'($signed(cfg_i.zero_drift));
    wire signed [17:0] bias_x = 18'($signed(cfg_i.bias));
    wire signed [17:0] b1     = filt_x - zd_x - bias_x;
    wire        [17:0] b1_abs = b1[17] ? 18'(-b1) : 18'(b1);
    wire               in_dz  = b1_abs < {2'b00, cfg_i.dead_zone};
    wire signed [17:0] b2     = in_dz ? 18'sd0 : b1;
    wire signed [35:0] prod   = b2 * $signed({1'b0, cfg_i.magnification});
    wire signed [35:0] quo    = prod / 36'(FULL_SCALE_MV);
    wire               hi     = quo > 36'(PCT_MAX);
    wire               lo     = quo < -36'(PCT_MAX);

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            pct_o <= '0;
        end else if (hi) begin
            pct_o <= 16'(PCT_MAX);
        end else if (lo) begin
            pct_o <= 16'(-PCT_MAX);
        end else begin
            pct_o <= quo[15:0];
        end
    end

endmodule : aic_cmd_calc

`default_nettype wire

// [bench/aic_top_assertions.sv]
// Purpose: Port-level checker for the analog input conditioning top
// Assumes: Sees only the top module ports, one clock domain
// Notes:   Bound to aic_top after the module
`timescale 1ns/10ps
`default_nettype none
module aic_top_assertions #(
    parameter int CYCLES_PER_MS = aic_pkg::MS_CYCLES
) (
    input  wire logic                     clk_i,
    input  wire logic                     reset_n_i,
    input  wire aic_pkg::aic_reg_req_type reg_req_i,
    input  wire logic [15:0]              reg_rdata_o,
    input  wire aic_pkg::aic_sample_type  sample_i,
    input  wire logic                     din_cal_i,
    input  wire logic [31:0]              speed_cmd_o,
    input  wire logic [15:0]              torque_pct_o
);
    import aic_pkg::*;
    // ********
    // Shadow state
    // ********
    logic [15:0]        rated;
    logic [15:0]        last_mv0;
    logic               seen;
    logic               src;
    logic [1:0]         cfg_age;
    logic [1:0]         next_age;
    logic signed [31:0] speed_exp;
    wire logic [4:0] a = reg_req_i.addr;
    wire logic rated_wr = reg_req_i.wr && a == REG_RATED_SPEED;
    wire logic src_wr = reg_req_i.wr && a == REG_CMD_SOURCE;
    wire logic rw_addr = (a >= 5'h02 && a <= 5'h05) || a == REG_RATED_SPEED
        || (a >= 5'h07 && a <= 5'h0a);
    assign next_age = (rated_wr || src_wr) ? 2'h0
        : (cfg_age == 2'h3 ? 2'h3 : cfg_age + 2'h1);
    assign speed_exp = $signed(torque_pct_o) * $signed({16'h0000, rated})
        / 1000;
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            rated <= RATED_RESET;
            src <= 1'b0;
            cfg_age <= 2'h0;
            last_mv0 <= 16'h0000;
            seen <= 1'b0;
        end else begin
            rated <= rated_wr ? reg_req_i.wdata : rated;
            src <= src_wr ? reg_req_i.wdata[0] : src;
            cfg_age <= next_age;
            last_mv0 <= sample_i.valid ? sample_i.mv[0] : last_mv0;
            seen <= seen || sample_i.valid;
        end
    end
    // ********
    // Properties
    // ********
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    sequence s_rw_write;
        reg_req_i.wr && rw_addr;
    endsequence
    sequence s_cal_write;
        reg_req_i.wr && a == REG_CAL_TRIGGER && reg_req_i.wdata < 16'h0008;
    endsequence
    sequence s_same_read;
        reg_req_i.rd && a == $past(a);
    endsequence
    a_rdata_idle: assert property (!reg_req_i.rd |=> reg_rdata_o == 16'h0)
        else $error("read data not zero outside read answer");
    a_volt_raw: assert property (reg_req_i.rd && a == REG_CH1_VOLT && seen
        && !sample_i.valid |=> reg_rdata_o == last_mv0)
        else $error("channel one voltage differs from last sample");
    a_unmapped_zero: assert property (reg_req_i.rd && a > REG_CMD_SOURCE
        |=> reg_rdata_o == 16'h0)
        else $error("unmapped read not zero");
    a_pct_torque: assert property (reg_req_i.rd && a == REG_CH1_PCT
        && !src && cfg_age == 2'h3 |=> reg_rdata_o == torque_pct_o)
        else $error("torque differs from channel one percent");
    a_speed_calc: assert property (cfg_age == 2'h3
        |-> speed_cmd_o == speed_exp)
        else $error("speed not rated speed times percent");
    a_reset_zero: assert property ($rose(reset_n_i) |-> speed_cmd_o == 32'h0
        && torque_pct_o == 16'h0 && reg_rdata_o == 16'h0)
        else $error("outputs not zero after reset");
    a_rw_readback: assert property (s_rw_write ##1 s_same_read
        |=> reg_rdata_o == $past(reg_req_i.wdata, 2))
        else $error("setting readback differs from write");
    a_cal_code: assert property (s_cal_write ##1 s_same_read
        |=> reg_rdata_o == $past(reg_req_i.wdata, 2))
        else $error("trigger code readback differs");
endmodule : aic_top_assertions
bind aic_top aic_top_assertions #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_chk (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .reg_req_i(reg_req_i),
    .reg_rdata_o(reg_rdata_o), .sample_i(sample_i), .din_cal_i(din_cal_i),
    .speed_cmd_o(speed_cmd_o), .torque_pct_o(torque_pct_o));
`default_nettype wire

// [bench/aic_src.sv]
// Purpose: Model of the external bipolar analog command source
// Assumes: Caller enters send at a rising edge
// Notes:   Sample lines show inverted data between frames
`timescale 1ns/10ps
`default_nettype none
module aic_src (
    input  wire logic                    clk_i,
    output var  aic_pkg::aic_sample_type sample_o
);
    import aic_pkg::*;
    initial sample_o = '0;
    task automatic send(input logic [15:0] mv0, input logic [15:0] mv1);
        sample_o <= '{1'b1, {mv1, mv0}};
        @(posedge clk_i);
        sample_o <= '{1'b0, {~mv1, ~mv0}};
        @(posedge clk_i);
    endtask : send
endmodule : aic_src
`default_nettype wire

// [bench/tb_top.sv]
// Purpose: Self-checking bench for the analog input conditioning top
// Assumes: Millisecond tick shortened to 4 cycles
// Notes:   Rows cover the arithmetic chain; hand tests follow
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) check(n, e, g)
module tb_top;
    import aic_pkg::*;
    typedef struct {
        logic [15:0] mv, zd, bias, dz, mag, pct;
    } aic_row_type;
    logic            clk_i;
    logic            reset_n_i;
    logic            din_cal_i;
    aic_reg_req_type req;
    aic_sample_type  smp;
    logic [15:0]     rdata;
    logic [15:0]     torque;
    logic [31:0]     speed;
    logic [15:0]     q;
    int              miscompares;
    int              comparisons;
    aic_row_type rows [8] = '{
        '{16'h1388, 16'h0, 16'h0, 16'h0, 16'h03e8, 16'h01f4},
        '{16'hd8f0, 16'h0, 16'h0, 16'h0, 16'h03e8, 16'hfc18},
        '{16'h1130, 16'h0190, 16'h0fa0, 16'h0320, 16'h03e8, 16'h0},
        '{16'h1450, 16'h0190, 16'h0fa0, 16'h0320, 16'h03e8, 16'h0050},
        '{16'h144f, 16'h0190, 16'h0fa0, 16'h0320, 16'h03e8, 16'h0},
        '{16'h0e0f, 16'h0, 16'h0fa0, 16'h0190, 16'h03e8, 16'hffd8},
        '{16'h2710, 16'h0, 16'h0, 16'h0, 16'h2710, 16'h2710},
        '{16'h1388, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0}};
    aic_top #(.CYCLES_PER_MS(4)) u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .reg_req_i(req), .reg_rdata_o(rdata), .sample_i(smp),
        .din_cal_i(din_cal_i), .speed_cmd_o(speed), .torque_pct_o(torque));
    aic_src u_src (.clk_i(clk_i), .sample_o(smp));
    // ********
    // Tasks
    // ********
    task automatic check(input string n, input logic [31:0] e,
                         input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : check
    task automatic do_reset;
        reset_n_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        reset_n_i <= 1'b1;
        @(posedge clk_i);
    endtask : do_reset
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge clk_i);
        req <= '0;
        @(posedge clk_i);
    endtask : wr
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        req <= '{1'b0, 1'b1, a, 16'h0};
        @(posedge clk_i);
        req <= '0;
        #1 d = rdata;
        @(posedge clk_i);
    endtask : rd
    task automatic wrrd(input logic [4:0] a, input logic [15:0] d,
                        output logic [15:0] v);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge clk_i);
        rd(a, v);
    endtask : wrrd
    task automatic rc(input string n, input logic [4:0] a,
                      input logic [15:0] e);
        logic [15:0] v;
        rd(a, v);
        `CHK(n, e, v);
    endtask : rc
    task automatic end_of_test;
        $display("Mismatches %0d of %0d comparisons", miscompares,
                 comparisons);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test
    // ********
    // Sequence
    // ********
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        end_of_test();
    end
    initial begin
        reset_n_i = 1'b0;
        din_cal_i = 1'b0;
        req = '0;
        miscompares = 0;
        comparisons = 0;
        do_reset();
        wr(5'h05, 16'h0);
        foreach (rows[i]) begin
            wr(5'h02, rows[i].bias);
            wr(5'h03, rows[i].dz);
            wr(5'h04, rows[i].mag);
            wr(5'h06, rows[i].zd);
            u_src.send(rows[i].mv, 16'h0);
            repeat (3) @(posedge clk_i);
            rc("ch1_volt", REG_CH1_VOLT, rows[i].mv);
            rc("ch1_pct", REG_CH1_PCT, rows[i].pct);
            `CHK("torque", rows[i].pct, torque);
            `CHK("speed", int'($signed(rows[i].pct)) * 3000 / 1000,
                 speed);
        end
        do_reset();
        rc("bias_rst", 5'h02, 16'h0);
        rc("dz_rst", 5'h03, 16'h0);
        rc("mag_rst", 5'h04, 16'h03e8);
        rc("tc_rst", 5'h05, 16'h0002);
        rc("zd_rst", 5'h06, 16'h0);
        rc("tc2_rst", 5'h0a, 16'h0002);
        u_src.send(16'h0fa0, 16'h0);
        rd(REG_CH1_PCT, q);
        `CHK("lpf_slow", 1'b1, $signed(q) < $signed(16'h0190));
        repeat (400) @(posedge clk_i);
        rd(REG_CH1_PCT, q);
        `CHK("lpf_end", 1'b1, q >= 16'h018f && q <= 16'h0190);
        wr(5'h05, 16'h0);
        u_src.send(16'h0fa0, 16'h0);
        rc("lpf_bypass", REG_CH1_PCT, 16'h0190);
        wr(5'h0a, 16'h0);
        wr(5'h09, 16'h01f4);
        u_src.send(16'h03e8, 16'hf830);
        rc("ch2_volt", REG_CH2_VOLT, 16'hf830);
        rc("ch2_pct", REG_CH2_PCT, 16'hff9c);
        rc("ch1_pct_ind", REG_CH1_PCT, 16'h0064);
        wr(REG_CMD_SOURCE, 16'h0001);
        wrrd(REG_RATED_SPEED, 16'h07d0, q);
        repeat (3) @(posedge clk_i);
        `CHK("torque2", 16'hff9c, torque);
        `CHK("speed2", 32'hffffff38, speed);
        wrrd(REG_CAL_TRIGGER, 16'h0001, q);
        `CHK("cal_code", 16'h0001, q);
        rc("drift_gone", REG_CH1_PCT, 16'h0);
        for (int c = 1; c <= 4; c++) begin
            wr(5'h06, 16'h0);
            wr(5'h0b, 16'h0);
            wr(REG_CAL_TRIGGER, 16'(c));
            rc("zd1", 5'h06, (c == 1 || c == 4) ? 16'h03e8 : 16'h0);
            rc("zd2", 5'h0b, (c == 2 || c == 4) ? 16'hf830 : 16'h0);
        end
        wr(5'h06, 16'h0);
        wr(5'h0b, 16'h0);
        u_src.send(16'h00fa, 16'h0096);
        din_cal_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rc("din_rise", 5'h06, 16'h0);
        din_cal_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rc("din_zd1", 5'h06, 16'h00fa);
        rc("din_zd2", 5'h0b, 16'h0096);
        wr(REG_CH1_PCT, 16'h1234);
        rc("ro_pct", REG_CH1_PCT, 16'h0);
        wr(REG_CH1_VOLT, 16'h1234);
        rc("ro_volt", REG_CH1_VOLT, 16'h00fa);
        rc("unmapped", 5'h1f, 16'h0);
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
